//--- common/usp_defs.vh
//==========================================================================
// What this block does
// - Five to eight data bits, both directions
// - One stop, or 1.5/2 extended stop
// - Parity even, odd, mark, space or none
// - Parity counts ones or zeros per sense
// - Line hold forces whole frame low
// - Break start and break end flags
// - Break never sets framing error flag
// - TX level flag on fall to threshold
// - RX level flag while count meets threshold
// - Full RX FIFO drops frame, flags overrun
// - CTS change flag on both edges
// - Framing and parity error flags on receive
// - Receive timeout flag after idle period
// - Clock source select; receive needs oscillator
// - Divider with prescale power of two
// - One data port for both FIFOs
// - Writes ignored while TX FIFO full
// - Peek shows next TX character, no pop
// - Short received characters right justified
// - CTS loss pauses after current character
// - RTS follows receive FIFO threshold
// - Timeout counts frames while FIFO holds data
//==========================================================================
`ifndef USP_DEFS_VH
`define USP_DEFS_VH

//==========================================================================
// Register byte offsets
`define USP_OFF_CTRL    6'h00
`define USP_OFF_THRESH  6'h04
`define USP_OFF_STATUS  6'h08
`define USP_OFF_IRQ_EN  6'h0c
`define USP_OFF_IRQ_FL  6'h10
`define USP_OFF_BAUD0   6'h14
`define USP_OFF_BAUD1   6'h18
`define USP_OFF_DATA    6'h1c
`define USP_OFF_PEEK    6'h24

//==========================================================================
// Control register fields
`define USP_CTRL_EN      0
`define USP_CTRL_PAR_EN  1
`define USP_CTRL_PAR_LO  2
`define USP_CTRL_PARMD   4
`define USP_CTRL_TXFL    5
`define USP_CTRL_RXFL    6
`define USP_CTRL_SIZE_LO 8
`define USP_CTRL_STOP    10
`define USP_CTRL_FLOW    11
`define USP_CTRL_FPOL    12
`define USP_CTRL_HOLD    14
`define USP_CTRL_CLKSEL  15
`define USP_CTRL_TO_LO   16
`define USP_CTRL_RST     24'h000010

//==========================================================================
// Threshold and baud fields
`define USP_THR_TX_LO    0
`define USP_THR_RX_LO    8
`define USP_THR_RTS_LO   16
`define USP_BAUD0_FAC_LO 16

//==========================================================================
// Interrupt flag bits
`define USP_FL_FRAME   0
`define USP_FL_PARITY  1
`define USP_FL_CTS     2
`define USP_FL_OVR     3
`define USP_FL_RXLVL   4
`define USP_FL_TIMEOUT 5
`define USP_FL_TXLVL   6
`define USP_FL_BRK     7
`define USP_FL_BRKEND  8
`define USP_NFLAGS     9

`endif

//--- src/usp_uart.v
`timescale 1ns/1ps
`include "usp_defs.vh"

module usp_uart #(
	parameter DEPTH = 8,	// FIFO depth in characters
	parameter AW    = 3	// log2 of DEPTH
) (
	// Clock and reset
	input  wire        i_clk,
	input  wire        i_resetn,
	// Register port
	input  wire [5:0]  i_addr,
	input  wire [31:0] i_wdata,
	input  wire        i_wr,
	input  wire        i_rd,
	output reg  [31:0] o_rdata,
	// Oscillator enable pulse, one cycle per oscillator period
	input  wire        i_osc_tick,
	// Serial line
	input  wire        i_rxd,
	output reg         o_txd,
	input  wire        i_cts,
	output reg         o_rts,
	// Interrupt
	output reg         o_irq
);

	//======================================================================
	// Local constants
	localparam [2:0] TS_IDLE = 3'h0, TS_START = 3'h1, TS_DATA = 3'h2,
	                 TS_PAR  = 3'h3, TS_STOP  = 3'h4;
	localparam [2:0] RS_IDLE = 3'h0, RS_START = 3'h1, RS_DATA = 3'h2,
	                 RS_PAR  = 3'h3, RS_STOP  = 3'h4, RS_BRK   = 3'h5;
	localparam [AW:0] FULL = DEPTH;

	//======================================================================
	// Software registers
	reg  [23:0] ctrl_r;		// Control
	reg  [21:0] thr_r;		// Thresholds
	reg  [`USP_NFLAGS-1:0] ien_r;	// Interrupt enables
	reg  [`USP_NFLAGS-1:0] ifl_r;	// Sticky flags
	reg  [18:0] baud0_r;		// Prescale and integer divisor
	reg  [6:0]  baud1_r;		// Fraction field

	wire       en       = ctrl_r[`USP_CTRL_EN];
	wire       par_en   = ctrl_r[`USP_CTRL_PAR_EN];
	wire [1:0] par_md   = ctrl_r[`USP_CTRL_PAR_LO+1:`USP_CTRL_PAR_LO];
	wire       par_ones = ctrl_r[`USP_CTRL_PARMD];
	wire [1:0] csize    = ctrl_r[`USP_CTRL_SIZE_LO+1:`USP_CTRL_SIZE_LO];
	wire       stop_ext = ctrl_r[`USP_CTRL_STOP];
	wire       flow     = ctrl_r[`USP_CTRL_FLOW];
	wire       fpol     = ctrl_r[`USP_CTRL_FPOL];
	wire       hold     = ctrl_r[`USP_CTRL_HOLD];
	wire       clksel   = ctrl_r[`USP_CTRL_CLKSEL];
	wire [7:0] idle_frames_limit = ctrl_r[`USP_CTRL_TO_LO+7:`USP_CTRL_TO_LO];
	wire [3:0] tx_thr   = thr_r[`USP_THR_TX_LO+3:`USP_THR_TX_LO];
	wire [3:0] rx_thr   = thr_r[`USP_THR_RX_LO+3:`USP_THR_RX_LO];
	wire [5:0] rts_thr  = thr_r[`USP_THR_RTS_LO+5:`USP_THR_RTS_LO];
	wire [2:0] factor   = baud0_r[`USP_BAUD0_FAC_LO+2:`USP_BAUD0_FAC_LO];
	wire [11:0] ibaud   = baud0_r[11:0];
	wire [3:0] nbits    = {2'b00, csize} + 4'd5;	// Data bits

	// Bus decode
	wire wr_ctrl = i_wr && (i_addr == `USP_OFF_CTRL);
	wire wr_data = i_wr && (i_addr == `USP_OFF_DATA);
	wire rd_data = i_rd && (i_addr == `USP_OFF_DATA);
	wire wr_fl   = i_wr && (i_addr == `USP_OFF_IRQ_FL);

	// Flush on request or while disabled
	wire tx_flush = !en || (wr_ctrl && i_wdata[`USP_CTRL_TXFL]);
	wire rx_flush = !en || (wr_ctrl && i_wdata[`USP_CTRL_RXFL]);

	//======================================================================
	// Parity of a character: ones or zeros count, then mode
	function par_bit;
		input [7:0] d;
		input [3:0] n;
		input [1:0] md;
		input       ones;
		reg         x;
		begin
			x = ^(d & ~(8'hff << n));
			if (!ones)
				x = x ^ n[0];		// Zero count parity
			case (md)
				2'h0:    par_bit = x;		// Even
				2'h1:    par_bit = ~x;	// Odd
				2'h2:    par_bit = 1'b1;	// Mark
				default: par_bit = 1'b0;	// Space
			endcase
		end
	endfunction

	//======================================================================
	// Fractional rate generator: emits a tick each DIV source periods
	reg  [19:0] acc_r;
	reg         tick_r;
	wire        src_en = clksel ? i_osc_tick : 1'b1;	// Source select
	wire [19:0] div128 = {1'b0, ibaud, 7'h00} + {13'h0, baud1_r};
	wire [19:0] acc_sum = acc_r + 20'h00080;
	wire [8:0]  tpb = 9'h001 << (3'h7 - factor);	// Ticks per bit
	wire        rx_tick = tick_r && clksel;	// Receiver only on oscillator

	// Accumulator advances by 128 per source period
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			acc_r  <= 20'h00000;
			tick_r <= 1'b0;
		end else begin
			tick_r <= 1'b0;
			if (!en || div128 < 20'h00080) begin
				acc_r <= 20'h00000;	// Divider below one: no ticks
			end else if (src_en) begin
				if (acc_sum >= div128) begin
					acc_r  <= acc_sum - div128;
					tick_r <= 1'b1;
				end else begin
					acc_r <= acc_sum;
				end
			end
		end
	end

	//======================================================================
	// FIFO storage, each side declares its own array
	reg  [7:0]  txm [0:DEPTH-1];
	reg  [7:0]  rxm [0:DEPTH-1];
	reg  [AW-1:0] txw_r, txr_r, rxw_r, rxr_r;
	reg  [AW:0] txc_r, rxc_r;
	wire        tx_push = wr_data && (txc_r != FULL);	// Full drops write
	reg         tx_pop;
	reg         rx_push;
	wire        rx_pop = rd_data && (rxc_r != 0);
	reg  [7:0]  rx_dat_r;

	// Transmit FIFO pointers and count
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			txw_r <= {AW{1'b0}};
			txr_r <= {AW{1'b0}};
			txc_r <= {(AW+1){1'b0}};
		end else if (tx_flush) begin
			txw_r <= {AW{1'b0}};
			txr_r <= {AW{1'b0}};
			txc_r <= {(AW+1){1'b0}};
		end else begin
			if (tx_push)
				txw_r <= txw_r + 1'b1;
			if (tx_pop)
				txr_r <= txr_r + 1'b1;
			if (tx_push && !tx_pop)
				txc_r <= txc_r + 1'b1;
			else if (tx_pop && !tx_push)
				txc_r <= txc_r - 1'b1;
		end
	end

	// Receive FIFO pointers and count
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rxw_r <= {AW{1'b0}};
			rxr_r <= {AW{1'b0}};
			rxc_r <= {(AW+1){1'b0}};
		end else if (rx_flush) begin
			rxw_r <= {AW{1'b0}};
			rxr_r <= {AW{1'b0}};
			rxc_r <= {(AW+1){1'b0}};
		end else begin
			if (rx_push)
				rxw_r <= rxw_r + 1'b1;
			if (rx_pop)
				rxr_r <= rxr_r + 1'b1;
			if (rx_push && !rx_pop)
				rxc_r <= rxc_r + 1'b1;
			else if (rx_pop && !rx_push)
				rxc_r <= rxc_r - 1'b1;
		end
	end

	// Array writes carry no reset; count guards every read
	always @(posedge i_clk) begin
		if (tx_push)
			txm[txw_r] <= i_wdata[7:0];
		if (rx_push)
			rxm[rxw_r] <= rx_dat_r;
	end

	//======================================================================
	// Transmitter
	reg  [2:0] ts_r;
	reg  [8:0] ttc_r;		// Tick within current bit
	reg  [3:0] tbi_r;		// Data bit index
	reg  [7:0] tsh_r;		// Shift register
	reg        tpar_r;
	reg        cts_prev_r;
	wire       cts_on  = (i_cts == fpol);
	wire [8:0] stop_len = !stop_ext ? tpb :
	                      (csize == 2'h0) ? tpb + {1'b0, tpb[8:1]} : {tpb[7:0], 1'b0};
	wire [8:0] tlen    = (ts_r == TS_STOP) ? stop_len : tpb;
	wire       tend    = tick_r && (ttc_r == tlen - 9'h001);
	wire       tx_go   = (txc_r != 0) && en && (!flow || cts_on);

	always @* begin
		tx_pop = (ts_r == TS_IDLE) && tx_go && !tx_flush;
	end

	// Frame sequencer: start, data LSB first, parity, stop
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ts_r   <= TS_IDLE;
			ttc_r  <= 9'h000;
			tbi_r  <= 4'h0;
			tsh_r  <= 8'h00;
			tpar_r <= 1'b0;
			o_txd  <= 1'b1;
		end else begin
			if (ts_r != TS_IDLE && tick_r)
				ttc_r <= tend ? 9'h000 : ttc_r + 9'h001;
			case (ts_r)
				TS_IDLE: begin
					if (tx_pop) begin
						tsh_r  <= txm[txr_r];
						tpar_r <= par_bit(txm[txr_r], nbits, par_md, par_ones);
						ttc_r  <= 9'h000;
						tbi_r  <= 4'h0;
						ts_r   <= TS_START;
					end
				end
				TS_START: begin
					if (tend)
						ts_r <= TS_DATA;
				end
				TS_DATA: begin
					if (tend) begin
						tsh_r <= {1'b0, tsh_r[7:1]};
						tbi_r <= tbi_r + 4'h1;
						if (tbi_r == nbits - 4'h1)
							ts_r <= par_en ? TS_PAR : TS_STOP;
					end
				end
				TS_PAR: begin
					if (tend)
						ts_r <= TS_STOP;
				end
				TS_STOP: begin
					if (tend)
						ts_r <= TS_IDLE;	// CTS rechecked before next char
				end
				default: ts_r <= TS_IDLE;
			endcase
			// Line level; hold forces every frame bit low
			if (ts_r != TS_IDLE && hold)
				o_txd <= 1'b0;
			else
				case (ts_r)
					TS_START: o_txd <= 1'b0;
					TS_DATA:  o_txd <= tsh_r[0];
					TS_PAR:   o_txd <= tpar_r;
					default:  o_txd <= 1'b1;
				endcase
		end
	end

	//======================================================================
	// Receiver
	reg  [2:0] rs_r;
	reg  [8:0] rtc_r;
	reg  [3:0] rbi_r;
	reg  [7:0] rsh_r;
	reg        rzero_r;		// Every sample so far was low
	reg        rperr_r;
	reg        ev_frame, ev_par, ev_ovr, ev_brk, ev_brkend;
	wire       rend  = rx_tick && (rtc_r == tpb - 9'h001);
	wire       rsmp  = rx_tick && (rtc_r == {1'b0, tpb[8:1]});	// Mid bit
	wire [7:0] rjust = rsh_r >> (4'h8 - nbits);	// Right justify

	// Sampling sequencer
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rs_r      <= RS_IDLE;
			rtc_r     <= 9'h000;
			rbi_r     <= 4'h0;
			rsh_r     <= 8'h00;
			rzero_r   <= 1'b0;
			rperr_r   <= 1'b0;
			rx_dat_r  <= 8'h00;
			rx_push   <= 1'b0;
			ev_frame  <= 1'b0;
			ev_par    <= 1'b0;
			ev_ovr    <= 1'b0;
			ev_brk    <= 1'b0;
			ev_brkend <= 1'b0;
		end else begin
			rx_push   <= 1'b0;
			ev_frame  <= 1'b0;
			ev_par    <= 1'b0;
			ev_ovr    <= 1'b0;
			ev_brk    <= 1'b0;
			ev_brkend <= 1'b0;
			if (rs_r != RS_IDLE && rx_tick)
				rtc_r <= rend ? 9'h000 : rtc_r + 9'h001;
			if (!en || !clksel) begin
				rs_r <= RS_IDLE;
			end else
				case (rs_r)
					RS_IDLE: begin
						if (rx_tick && !i_rxd) begin
							// This tick already saw the start bit; at one tick a bit it is over
							rs_r    <= (tpb == 9'h001) ? RS_DATA : RS_START;
							rtc_r   <= (tpb == 9'h001) ? 9'h000 : 9'h001;
							rbi_r   <= 4'h0;
							rzero_r <= 1'b1;
							rperr_r <= 1'b0;
						end
					end
					RS_START: begin
						if (rsmp && i_rxd) begin
							ev_frame <= 1'b1;	// Start lost
							rs_r     <= RS_IDLE;
						end else if (rend)
							rs_r <= RS_DATA;
					end
					RS_DATA: begin
						if (rsmp) begin
							rsh_r   <= {i_rxd, rsh_r[7:1]};
							rzero_r <= rzero_r & ~i_rxd;
							rbi_r   <= rbi_r + 4'h1;
						end
						// At one or two ticks a bit the last sample shares this edge
						if (rend && rbi_r + {3'h0, rsmp} == nbits)
							rs_r <= par_en ? RS_PAR : RS_STOP;
					end
					RS_PAR: begin
						if (rsmp) begin
							rperr_r <= i_rxd != par_bit(rjust, nbits, par_md, par_ones);
							rzero_r <= rzero_r & ~i_rxd;
						end
						if (rend)
							rs_r <= RS_STOP;
					end
					RS_STOP: begin
						if (rsmp) begin
							rs_r <= RS_IDLE;
							if (i_rxd) begin
								if (rxc_r == FULL && !rx_pop)
									ev_ovr <= 1'b1;	// Frame dropped
								else begin
									rx_dat_r <= rjust;
									rx_push  <= 1'b1;
								end
								ev_par <= rperr_r;
							end else if (rzero_r) begin
								ev_brk <= 1'b1;	// Break, no frame error
								rs_r   <= RS_BRK;
							end else
								ev_frame <= 1'b1;	// Stop lost
						end
					end
					RS_BRK: begin
						if (i_rxd) begin
							ev_brkend <= 1'b1;	// Line released
							rs_r      <= RS_IDLE;
						end
					end
					default: rs_r <= RS_IDLE;
				endcase
		end
	end

	//======================================================================
	// Receive timeout: frames counted while FIFO holds data
	reg  [8:0] tob_r;		// Ticks within a bit
	reg  [3:0] tof_r;		// Bits within a frame
	reg  [7:0] ton_r;		// Frames elapsed
	reg        ev_to;
	wire [3:0] fbits = 4'h2 + nbits + {3'h0, par_en} + {3'h0, stop_ext};

	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tob_r <= 9'h000;
			tof_r <= 4'h0;
			ton_r <= 8'h00;
			ev_to <= 1'b0;
		end else begin
			ev_to <= 1'b0;
			if (rxc_r == 0 || rx_push || idle_frames_limit == 8'h00) begin
				tob_r <= 9'h000;
				tof_r <= 4'h0;
				ton_r <= 8'h00;
			end else if (rx_tick && ton_r != idle_frames_limit) begin
				tob_r <= (tob_r == tpb - 9'h001) ? 9'h000 : tob_r + 9'h001;
				if (tob_r == tpb - 9'h001) begin
					tof_r <= (tof_r == fbits - 4'h1) ? 4'h0 : tof_r + 4'h1;
					if (tof_r == fbits - 4'h1) begin
						ton_r <= ton_r + 8'h01;
						ev_to <= (ton_r + 8'h01 == idle_frames_limit);
					end
				end
			end
		end
	end

	//======================================================================
	// Event collection and sticky flags
	reg  [AW:0] txc_prev_r;
	reg  [`USP_NFLAGS-1:0] ev;

	always @* begin
		ev = {`USP_NFLAGS{1'b0}};
		ev[`USP_FL_FRAME]   = ev_frame;
		ev[`USP_FL_PARITY]  = ev_par;
		ev[`USP_FL_OVR]     = ev_ovr;
		ev[`USP_FL_TIMEOUT] = ev_to;
		ev[`USP_FL_BRK]     = ev_brk;
		ev[`USP_FL_BRKEND]  = ev_brkend;
		ev[`USP_FL_CTS]     = flow && (cts_on != cts_prev_r);
		ev[`USP_FL_RXLVL]   = ({{(7-AW){1'b0}}, rxc_r} >= {4'h0, rx_thr});
		ev[`USP_FL_TXLVL]   = ({{(7-AW){1'b0}}, txc_prev_r} > {4'h0, tx_thr}) &&
		                      ({{(7-AW){1'b0}}, txc_r} == {4'h0, tx_thr});
	end

	// Set wins over a simultaneous write-one clear
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ifl_r      <= {`USP_NFLAGS{1'b0}};
			cts_prev_r <= 1'b0;
			txc_prev_r <= {(AW+1){1'b0}};
			o_irq      <= 1'b0;
			o_rts      <= 1'b0;
		end else begin
			ifl_r      <= (ifl_r & ~(wr_fl ? i_wdata[`USP_NFLAGS-1:0] : {`USP_NFLAGS{1'b0}})) | ev;
			cts_prev_r <= cts_on;
			txc_prev_r <= txc_r;
			o_irq      <= |(ifl_r & ien_r);
			// Deasserted at or above threshold, else asserted
			if (flow && {{(6-AW-1){1'b0}}, rxc_r} >= rts_thr)
				o_rts <= ~fpol;
			else
				o_rts <= fpol;
		end
	end

	//======================================================================
	// Register writes; flush bits are pulses and read back zero
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_r  <= `USP_CTRL_RST;
			thr_r   <= 22'h000000;
			ien_r   <= {`USP_NFLAGS{1'b0}};
			baud0_r <= 19'h00000;
			baud1_r <= 7'h00;
		end else if (i_wr) begin
			case (i_addr)
				`USP_OFF_CTRL:   ctrl_r  <= i_wdata[23:0] & 24'hffdf9f;
				`USP_OFF_THRESH: thr_r   <= i_wdata[21:0] & 22'h3f0f0f;
				`USP_OFF_IRQ_EN: ien_r   <= i_wdata[`USP_NFLAGS-1:0];
				`USP_OFF_BAUD0:  baud0_r <= i_wdata[18:0] & 19'h70fff;
				`USP_OFF_BAUD1:  baud1_r <= i_wdata[6:0];
				default:         ;
			endcase
		end
	end

	// Read data in the cycle after the strobe; unmapped reads zero
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 32'h00000000;
		end else if (i_rd) begin
			case (i_addr)
				`USP_OFF_CTRL:   o_rdata <= {8'h00, ctrl_r};
				`USP_OFF_THRESH: o_rdata <= {10'h000, thr_r};
				`USP_OFF_STATUS: o_rdata <= {16'h0000,
				                             {(8-AW-1){1'b0}}, txc_r,
				                             {(8-AW-1){1'b0}}, rxc_r} |
				                            {30'h0, rs_r != RS_IDLE, ts_r != TS_IDLE} << 16;
				`USP_OFF_IRQ_EN: o_rdata <= {{(32-`USP_NFLAGS){1'b0}}, ien_r};
				`USP_OFF_IRQ_FL: o_rdata <= {{(32-`USP_NFLAGS){1'b0}}, ifl_r};
				`USP_OFF_BAUD0:  o_rdata <= {13'h0000, baud0_r};
				`USP_OFF_BAUD1:  o_rdata <= {25'h0000000, baud1_r};
				`USP_OFF_DATA:   o_rdata <= (rxc_r != 0) ? {24'h000000, rxm[rxr_r]} : 32'h0;
				`USP_OFF_PEEK:   o_rdata <= (txc_r != 0) ? {24'h000000, txm[txr_r]} : 32'h0;
				default:         o_rdata <= 32'h00000000;
			endcase
		end
	end

endmodule // usp_uart

//--- verification/uart_serial_port_bench.sv
`timescale 1ns/1ps
`include "usp_defs.vh"
// ================================================
// Self-checking bench for the serial port
module uart_serial_port_bench;
	logic        i_clk = 1'b0;	// 25 MHz
	logic        i_resetn = 1'b0;	// Async, active low
	logic [5:0]  i_addr = 6'h00;	// Register port
	logic [31:0] i_wdata = 32'h0;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic        i_osc_tick = 1'b1;	// Tick every cycle: one cycle per bit
	logic        i_rxd;	// From the far end
	logic        i_cts;
	logic [31:0] o_rdata;
	logic        o_txd;
	logic        o_rts;
	logic        o_irq;
	int          num_errors = 0;
	int          checks = 0;
	logic [31:0] seed = 32'hec5c;	// Fixed seed keeps runs repeatable
	logic [31:0] rv;	// Last read data
	logic [23:0] c;	// Control setting in use
	logic [7:0]  q[$];	// Characters in flight
	always #20 i_clk = ~i_clk;
	usp_uart u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_osc_tick(i_osc_tick), .i_rxd(i_rxd),
		.o_txd(o_txd), .i_cts(i_cts), .o_rts(o_rts), .o_irq(o_irq));
	usp_serial_dev u_dev (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(i_rxd), .o_cts(i_cts));
	// ================================================
	// Expectations
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function automatic logic [7:0] msk();
		return ~(8'hff << (5 + c[9:8]));
	endfunction
	function automatic int flen();
		return 6 + c[9:8] + c[1] + (c[10] ? 2 : 1);
	endfunction
	// Line bits of one character under the control in use
	function automatic logic [11:0] frame(input logic [7:0] d);
		logic [11:0] f;
		logic        p;
		d = d & msk();
		p = c[4] ? ^d : ^(~d & msk());	// Count ones or zeros
		p = c[3] ? ~c[2] : p ^ c[2];	// Mark and space fixed, odd inverts
		f = 12'hffe;	// Start low, stops high
		for (int i = 0; i < 5 + c[9:8]; i++)
			f[i + 1] = d[i];
		if (c[1])
			f[6 + c[9:8]] = p;
		return f;
	endfunction
	// ================================================
	// Bus and check tasks
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);	// Gap so the strobe is never re-raised at once
	endtask
	task automatic rd(input logic [5:0] a);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
		rv = o_rdata;	// Data hold until the next read
	endtask
	task automatic wait_cap(input int n);
		for (int i = 0; i < 500 && u_dev.cap_q.size() < n; i++)
			@(posedge i_clk);
	endtask
	// Setup in the fixed order, enable last
	task automatic cfg(input logic [31:0] thr);
		wr(`USP_OFF_CTRL, 32'h0);
		wr(`USP_OFF_CTRL, {8'h00, c});
		wr(`USP_OFF_THRESH, thr);
		wr(`USP_OFF_BAUD0, 32'h0007_0001);	// Divider 1 at prescale 7
		wr(`USP_OFF_BAUD1, 32'h0);	// Whole divider, no fraction
		wr(`USP_OFF_CTRL, {8'h00, c | 24'h60});	// Flush both
		wr(`USP_OFF_IRQ_FL, 32'h3ff);
		wr(`USP_OFF_IRQ_EN, 32'h1ff);
		wr(`USP_OFF_CTRL, {8'h00, c | 24'h1});
		u_dev.cap_q.delete();
		u_dev.nb = flen();
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Watchdog well past the expected run length
	initial begin
		repeat (30000) @(posedge i_clk);
		num_errors++;
		wrap_up();
	end
	// ================================================
	// Scenarios
	initial begin
		repeat (16) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		rd(`USP_OFF_CTRL);
		chk(rv, 32'h10);
		for (int m = 0; m < 40; m++) begin
			q = {rnd(), rnd()};
			c = {14'h0020, m[1:0], 8'h00};	// Oscillator clock
			c[10] = (m % 4 != 0) && seed[8];	// 1.5 stops untestable at one tick a bit
			c[4] = m >= 20;
			if ((m / 4) % 5 != 4)
				c[3:1] = {2'((m / 4) % 5), 1'b1};
			cfg(32'h0);
			wr(`USP_OFF_DATA, {24'h0, q[0]});
			wr(`USP_OFF_DATA, {24'h0, q[1]});
			wait_cap(2);
			chk(u_dev.cap_q.pop_front(), frame(q[0]));
			chk(u_dev.cap_q.pop_front(), frame(q[1]));
			u_dev.send(frame(q[0]), flen());
			repeat (4) @(posedge i_clk);
			rd(`USP_OFF_DATA);
			chk(rv, {24'h0, q[0] & msk()});
		end
		$display("formats done");
		c = 24'h008302;	// 8 bits, even parity
		cfg(32'h0800);
		for (int e = 0; e < 3; e++) begin
			u_dev.send(e == 0 ? frame(8'h5a) ^ 12'h200 : e == 1 ? frame(8'h5a) & 12'hbff : 12'h0, 11);
			repeat (4) @(posedge i_clk);
			rd(`USP_OFF_IRQ_FL);
			chk(rv[8:0], e == 0 ? 9'h002 : e == 1 ? 9'h001 : 9'h180);
			chk(o_irq, 1'b1);
			wr(`USP_OFF_IRQ_FL, 32'h1ff);
			rd(`USP_OFF_IRQ_FL);
			chk(rv[8:0], 9'h0);
		end
		$display("receive errors done");
		c = 24'h009b00;	// 8N1, flow control, active high
		cfg(32'h0006_0400);
		q.delete();
		for (int i = 0; i < 9; i++) begin
			q.push_back(rnd());
			u_dev.send(frame(q[i]), 10);	// Ignores the handshake on purpose
			repeat (4) @(posedge i_clk);
			rd(`USP_OFF_IRQ_FL);
			chk(rv[4], i >= 3);
			chk(rv[3], i == 8);
			chk(o_rts, i < 5);
		end
		rd(`USP_OFF_STATUS);
		chk(rv[7:0], 8'd8);
		for (int i = 0; i < 9; i++) begin
			rd(`USP_OFF_DATA);
			chk(rv, i < 8 ? {24'h0, q[i]} : 32'h0);
		end
		chk(o_rts, 1'b1);
		$display("overrun done");
		cfg(32'h0006_0402);
		q.delete();
		for (int i = 0; i < 9; i++) begin
			q.push_back(rnd());
			wr(`USP_OFF_DATA, {24'h0, q[i]});
		end
		rd(`USP_OFF_PEEK);
		chk(rv, {24'h0, q[0]});
		rd(`USP_OFF_STATUS);
		chk(rv[15:8], 8'd8);
		repeat (40) @(posedge i_clk);
		chk(u_dev.cap_q.size(), 0);
		u_dev.o_cts <= 1'b1;
		wait_cap(8);
		repeat (40) @(posedge i_clk);
		chk(u_dev.cap_q.size(), 8);
		for (int i = 0; i < 8; i++)
			chk(u_dev.cap_q.pop_front(), frame(q[i]));
		rd(`USP_OFF_IRQ_FL);
		chk(rv[6], 1'b1);
		chk(rv[2], 1'b1);
		$display("transmit full done");
		c = 24'h00c300;	// Line held low
		cfg(32'h0);
		wr(`USP_OFF_DATA, 32'hff);
		wait_cap(1);
		chk(u_dev.cap_q.pop_front(), 12'hc00);
		c = 24'h038300;	// Timeout after 3 idle frames
		cfg(32'h0800);
		u_dev.send(frame(8'h3c), 10);
		repeat (4) @(posedge i_clk);
		rd(`USP_OFF_IRQ_FL);
		chk(rv[5], 1'b0);
		repeat (40) @(posedge i_clk);
		rd(`USP_OFF_IRQ_FL);
		chk(rv[5], 1'b1);
		rd(`USP_OFF_IRQ_EN);
		chk(rv, 32'h1ff);
		rd(6'h20);
		chk(rv, 32'h0);
		c = 24'h000300;	// Peripheral clock: receiver stays idle
		cfg(32'h0);
		u_dev.send(frame(8'h3c), 10);
		repeat (4) @(posedge i_clk);
		rd(`USP_OFF_STATUS);
		chk(rv[7:0], 8'h0);
		$display("break, timeout, clock source done");
		wrap_up();
	end
endmodule // uart_serial_port_bench

//--- verification/usp_serial_dev.sv
`timescale 1ns/1ps
// ================================================
// Far-end serial device, one clock per bit
module usp_serial_dev (
	// Clock
	input wire logic i_clk,
	// Line
	input wire logic i_txd,
	output logic     o_rxd,
	output logic     o_cts
);
	int          nb = 10;	// Bits per captured frame, start included
	logic [11:0] cap_q[$];	// Captured frames, bit 0 is the start bit
	logic [11:0] sh;	// Frame being assembled
	int          k = 0;	// Bits taken so far; 0 while idle
	initial begin
		o_rxd = 1'b1;	// Idle high
		o_cts = 1'b0;
	end
	// Capture: a low line in idle starts a frame
	always @(posedge i_clk) begin
		if (k == 0 && i_txd === 1'b0) begin
			sh = 12'hffe;	// Bits past the frame read high
			k = 1;
		end else if (k != 0) begin
			sh[k] = i_txd;	// LSB first after start
			k++;
			if (k == nb) begin
				cap_q.push_back(sh);
				k = 0;
			end
		end
	end
	// Drive n line bits, then back to idle
	task automatic send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			o_rxd <= f[i];
		end
		@(posedge i_clk);
		o_rxd <= 1'b1;
	endtask
endmodule // usp_serial_dev

//--- verification/usp_uart_properties.sv
`timescale 1ns/1ps
`include "usp_defs.vh"
// ================================================
// Port checks for the serial port
module usp_chk #(
	parameter DEPTH = 8	// FIFO depth
) (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_resetn,
	// Register port
	input wire logic [5:0]  i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [31:0] o_rdata,
	// Line and interrupt
	input wire logic        o_txd,
	input wire logic        i_cts,
	input wire logic        o_rts,
	input wire logic        o_irq
);
	// Longest frame at one cycle per bit, with margin; slower rates need more
	localparam int CTS_WAIT = 40;
	logic [23:0] ctl_r;	// Control as last written
	logic [8:0]  ien_r;	// Interrupt enables as last written
	logic [7:0]  held_r;	// Cycles of withheld CTS under flow control
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	// Shadow control and enable writes; count withheld CTS
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ctl_r  <= 24'h000010;
			ien_r  <= 9'h000;
			held_r <= 8'h00;
		end else begin
			if (i_wr && i_addr == `USP_OFF_CTRL)
				ctl_r <= i_wdata[23:0] & 24'hffdf1f;	// Flush pulses read 0
			if (i_wr && i_addr == `USP_OFF_IRQ_EN)
				ien_r <= i_wdata[8:0];
			if (!ctl_r[11] || i_cts == ctl_r[12])
				held_r <= 8'h00;
			else if (held_r != 8'hff)
				held_r <= held_r + 8'h01;	// Saturates
		end
	end
	a_rdata_hold: assert property (!$past(i_rd) |-> $stable(o_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (i_rd && i_addr == 6'h20 |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_back: assert property (i_rd && i_addr == `USP_OFF_CTRL
		|=> (o_rdata & 32'h00ffdf7f) == {8'h00, $past(ctl_r)}) else $error("control readback");
	a_ien_back: assert property (i_rd && i_addr == `USP_OFF_IRQ_EN
		|=> o_rdata[8:0] == $past(ien_r)) else $error("enable readback");
	a_irq_gated: assert property (ien_r == 9'h0 && $past(ien_r) == 9'h0 |-> !o_irq)
		else $error("interrupt with all enables off");
	a_rts_idle: assert property (!ctl_r[11] && $stable(ctl_r) |-> o_rts == ctl_r[12])
		else $error("handshake output wrong with flow off");
	a_count_bound: assert property (i_rd && i_addr == `USP_OFF_STATUS
		|=> o_rdata[7:0] <= DEPTH && o_rdata[15:8] <= DEPTH) else $error("fill count");
	a_char_narrow: assert property (i_rd && (i_addr == `USP_OFF_DATA ||
		i_addr == `USP_OFF_PEEK) |=> o_rdata[31:8] == 24'h0) else $error("upper data bits");
	a_cts_pause: assert property (held_r >= CTS_WAIT |-> o_txd)
		else $error("sent while clear to send withheld");
endmodule // usp_chk

bind usp_uart usp_chk #(.DEPTH(DEPTH)) u_chk (
	.i_clk    (i_clk),
	.i_resetn (i_resetn),
	.i_addr   (i_addr),
	.i_wdata  (i_wdata),
	.i_wr     (i_wr),
	.i_rd     (i_rd),
	.o_rdata  (o_rdata),
	.o_txd    (o_txd),
	.i_cts    (i_cts),
	.o_rts    (o_rts),
	.o_irq    (o_irq)
);
